// *** mci_defines.svh ***
`ifndef MCI_DEFINES_SVH
`define MCI_DEFINES_SVH

// command codes written over the data pins
`define MCI_CMD_READ 8'h00
`define MCI_CMD_SETUP_ERASE 8'h20
`define MCI_CMD_SETUP_PGM 8'h40
`define MCI_CMD_ERASE_VERIFY 8'hA0
`define MCI_CMD_RESET 8'hFF

// array layout and erased value
`define MCI_ERASED_BYTE 8'hFF
`define MCI_ERASE_START 17'h0_0000
`define MCI_LAST_ADDR 17'h1_FFFF

// pulse limits (25 program pulses, 30 erase pulses)
`define MCI_MAX_PGM_PULSES 5'h19
`define MCI_MAX_ERASE_PULSES 5'h1E

// clock rate and times in their own units
`define MCI_CLK_MHZ 250
`define MCI_PGM_PULSE_NS 10000
`define MCI_ERASE_PULSE_MS 100
`define MCI_SETTLE_NS 1000
`define MCI_T_SETUP_NS 20
`define MCI_T_WE_NS 100
`define MCI_T_ACC_NS 150
`define MCI_T_HOLD_NS 20

// least times round up to whole cycles, longest times round down
`define MCI_NS_UP(ns) ((((ns) * `MCI_CLK_MHZ) + 999) / 1000)
`define MCI_NS_DN(ns) (((ns) * `MCI_CLK_MHZ) / 1000)

`endif

// *** mci_pkg.sv ***
package mci_pkg;

   typedef enum logic [2:0] {
      MCI_OP_READ    = 3'h0,
      MCI_OP_IDENT   = 3'h1,
      MCI_OP_PROGRAM = 3'h2,
      MCI_OP_ERASE   = 3'h3,
      MCI_OP_RESET   = 3'h4
   } mci_op_e;

   typedef enum logic [1:0] {
      CYC_IDLE   = 2'h0,
      CYC_SETUP  = 2'h1,
      CYC_STROBE = 2'h2,
      CYC_HOLD   = 2'h3
   } mci_cyc_e;

   typedef enum logic [4:0] {
      ST_IDLE     = 5'h00,
      ST_SETTLE   = 5'h01,
      ST_RD       = 5'h02,
      ST_PG_SETUP = 5'h03,
      ST_PG_DATA  = 5'h04,
      ST_PG_PULSE = 5'h05,
      ST_PG_VCMD  = 5'h06,
      ST_PG_VREAD = 5'h07,
      ST_ER_SETUP = 5'h08,
      ST_ER_GO    = 5'h09,
      ST_ER_PULSE = 5'h0A,
      ST_ER_VCMD  = 5'h0B,
      ST_ER_VREAD = 5'h0C,
      ST_RST1     = 5'h0D,
      ST_RST2     = 5'h0E,
      ST_RDCMD    = 5'h0F,
      ST_DONE     = 5'h10
   } mci_state_e;

endpackage

// *** mci_tmr.sv ***
`timescale 1ns/1ps
`include "mci_defines.svh"

module mci_tmr (
   input wire logic clk, // system clock
   input wire logic rst_n, // synchronised reset, active low
   input wire logic load, // start a wait of count cycles
   input wire logic [24:0] count, // wait length, at least one
   output logic expired // one-cycle pulse at the end of the wait
);

   logic [24:0] cnt_reg;
   logic run_reg;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_reg <= 25'h000_0000;
         run_reg <= 1'b0;
         expired <= 1'b0;
      end else begin
         expired <= run_reg && (cnt_reg == 25'h000_0001);
         if (load) begin
            cnt_reg <= count;
            run_reg <= 1'b1;
         end else if (run_reg) begin
            cnt_reg <= cnt_reg - 25'h000_0001;
            run_reg <= (cnt_reg != 25'h000_0001);
         end
      end
   end

endmodule

// *** mci_cyc.sv ***
`timescale 1ns/1ps
`include "mci_defines.svh"

module mci_cyc (
   input wire logic clk, // system clock
   input wire logic rst_n, // synchronised reset, active low
   input wire logic start, // begin one bus cycle
   input wire logic wr, // 1 write cycle, 0 read cycle
   input wire logic [16:0] addr, // cycle address
   input wire logic [7:0] wdata, // write data
   input wire logic [7:0] dq_i, // data pins as seen
   output logic done, // one-cycle pulse at cycle end
   output logic [7:0] rdata, // data caught on a read
   output logic [16:0] pin_addr, // address pins
   output logic [7:0] pin_dq, // data pins driven value
   output logic pin_dq_oe, // data pins driven while high
   output logic pin_ce_n, // chip select, active low
   output logic pin_oe_n, // output gate, active low
   output logic pin_we_n // write strobe, active low
);

   localparam logic [7:0] T_SETUP = 8'(`MCI_NS_UP(`MCI_T_SETUP_NS));
   localparam logic [7:0] T_WE = 8'(`MCI_NS_UP(`MCI_T_WE_NS));
   localparam logic [7:0] T_ACC = 8'(`MCI_NS_UP(`MCI_T_ACC_NS));
   localparam logic [7:0] T_HOLD = 8'(`MCI_NS_UP(`MCI_T_HOLD_NS));

   mci_pkg::mci_cyc_e state_reg;
   logic [7:0] cnt_reg;
   logic wr_reg;
   wire cnt_zero = (cnt_reg == 8'h00);
   wire [7:0] cnt_dec = cnt_reg - 8'h01;

   // address and data stay put for the whole cycle, so they are valid at both strobe edges
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= mci_pkg::CYC_IDLE;
         cnt_reg <= 8'h00;
         wr_reg <= 1'b0;
         done <= 1'b0;
         rdata <= 8'h00;
         pin_addr <= 17'h0_0000;
         pin_dq <= 8'h00;
         pin_dq_oe <= 1'b0;
         pin_ce_n <= 1'b1;
         pin_oe_n <= 1'b1;
         pin_we_n <= 1'b1;
      end else begin
         done <= 1'b0;
         unique case (state_reg)
            mci_pkg::CYC_IDLE: if (start) begin
               state_reg <= mci_pkg::CYC_SETUP;
               cnt_reg <= T_SETUP - 8'h01;
               wr_reg <= wr;
               pin_addr <= addr;
               pin_dq <= wdata;
               pin_dq_oe <= wr;
               pin_ce_n <= 1'b0;
            end
            mci_pkg::CYC_SETUP: if (cnt_zero) begin
               state_reg <= mci_pkg::CYC_STROBE;
               cnt_reg <= (wr_reg ? T_WE : T_ACC) - 8'h01;
               pin_we_n <= ~wr_reg;
               pin_oe_n <= wr_reg;
            end else begin
               cnt_reg <= cnt_dec;
            end
            mci_pkg::CYC_STROBE: if (cnt_zero) begin
               state_reg <= mci_pkg::CYC_HOLD;
               cnt_reg <= T_HOLD - 8'h01;
               pin_we_n <= 1'b1;
               pin_oe_n <= 1'b1;
               if (!wr_reg) begin
                  rdata <= dq_i;
               end
            end else begin
               cnt_reg <= cnt_dec;
            end
            mci_pkg::CYC_HOLD: if (cnt_zero) begin
               state_reg <= mci_pkg::CYC_IDLE;
               done <= 1'b1;
               pin_ce_n <= 1'b1;
               pin_dq_oe <= 1'b0;
            end else begin
               cnt_reg <= cnt_dec;
            end
         endcase
      end
   end

endmodule

// *** mci_host.sv ***
// Functional notes
// - Erase verification starts at address zero and expects every byte all ones.
// - A failing byte triggers a whole-chip re-erase, at most thirty 100 ms pulses.
// - Verification resumes at the last failing address after the next erase pulse.
// - One byte at a time, at most twenty-five 10 us program pulses per byte.
// - Every program pulse is followed by a program verify before moving on.
// - After set-up program the first reset is null data; the second one aborts.
// - Always issue the reset command twice in a row.
// - Programming opens with the set-up code, then the address and data write.
// - Program verify reads with select and gate low, strobe high, supply high.
// - Identify: high voltage on trigger line, other lines low, address bit 0 picks the byte.
// - The read command with the supply high gives array reads until changed.
// - Erase set-up is written twice; erase runs until the next strobe rises.
// - Each erase is followed by erase verify carrying the address to check.
`timescale 1ns/1ps
`include "mci_defines.svh"

module mci_host #(
   parameter int unsigned ERASE_PULSE_CYC = `MCI_ERASE_PULSE_MS * 1000 * `MCI_CLK_MHZ,
   parameter logic [7:0] PGM_VERIFY_CMD = 8'hC0
) (
   input wire logic mclk, // system clock
   input wire logic rstn, // reset, active low
   input wire logic req_valid, // request strobe
   input wire mci_pkg::mci_op_e req_op, // requested operation
   input wire logic [16:0] req_addr, // byte address, bit 0 picks the identifier
   input wire logic [7:0] req_data, // byte to program
   output logic req_ready, // controller idle
   output logic rsp_valid, // one-cycle end of operation
   output logic [7:0] rsp_data, // last byte read
   output logic rsp_fail, // limit hit or identifier parity bad
   output logic [16:0] mem_addr, // address pins
   output logic [7:0] mem_dq_o, // data pins driven value
   output logic mem_dq_oe, // data pins driven while high
   input wire logic [7:0] mem_dq_i, // data pins as seen
   output logic mem_ce_n, // chip select, active low
   output logic mem_oe_n, // output gate, active low
   output logic mem_we_n, // write strobe, active low
   output logic program_supply_high, // request high program supply
   output logic identify_trigger_hv // request high voltage on identify trigger line
);

   localparam logic [24:0] PGM_PULSE_CYC = 25'(`MCI_NS_DN(`MCI_PGM_PULSE_NS));
   localparam logic [24:0] SETTLE_CYC = 25'(`MCI_NS_UP(`MCI_SETTLE_NS));

   logic rst_meta_reg;
   logic rst_n_reg;

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         rst_meta_reg <= 1'b0;
         rst_n_reg <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_n_reg <= rst_meta_reg;
      end
   end

   mci_pkg::mci_state_e state_reg, state_next;
   mci_pkg::mci_op_e op_reg;
   logic [16:0] addr_reg, vaddr_reg, vaddr_next;
   logic [7:0] data_reg;
   logic [4:0] pcount_reg, pcount_next, ecount_reg, ecount_next;
   logic fail_reg, fail_next, act_reg;
   logic cyc_done, tmr_exp;
   logic [7:0] cyc_rdata;

   wire st_idle = (state_reg == mci_pkg::ST_IDLE);
   wire take_req = st_idle && req_valid;
   wire is_cyc = (state_reg != mci_pkg::ST_IDLE) && (state_reg != mci_pkg::ST_SETTLE)
      && (state_reg != mci_pkg::ST_PG_PULSE) && (state_reg != mci_pkg::ST_ER_PULSE)
      && (state_reg != mci_pkg::ST_DONE);
   wire is_tmr = (state_reg == mci_pkg::ST_SETTLE) || (state_reg == mci_pkg::ST_PG_PULSE)
      || (state_reg == mci_pkg::ST_ER_PULSE);
   wire cyc_start = is_cyc && !act_reg;
   wire tmr_load = is_tmr && !act_reg;
   wire is_read = (state_reg == mci_pkg::ST_RD) || (state_reg == mci_pkg::ST_PG_VREAD)
      || (state_reg == mci_pkg::ST_ER_VREAD);
   wire on_vaddr = (state_reg == mci_pkg::ST_ER_VCMD) || (state_reg == mci_pkg::ST_ER_VREAD);
   wire [16:0] cyc_addr = on_vaddr ? vaddr_reg : addr_reg;
   wire [7:0] cyc_wdata =
      (state_reg == mci_pkg::ST_PG_SETUP) ? `MCI_CMD_SETUP_PGM :
      (state_reg == mci_pkg::ST_PG_DATA) ? data_reg :
      (state_reg == mci_pkg::ST_PG_VCMD) ? PGM_VERIFY_CMD :
      (state_reg == mci_pkg::ST_ER_SETUP) ? `MCI_CMD_SETUP_ERASE :
      (state_reg == mci_pkg::ST_ER_GO) ? `MCI_CMD_SETUP_ERASE :
      (state_reg == mci_pkg::ST_ER_VCMD) ? `MCI_CMD_ERASE_VERIFY :
      (state_reg == mci_pkg::ST_RST1) ? `MCI_CMD_RESET :
      (state_reg == mci_pkg::ST_RST2) ? `MCI_CMD_RESET :
      `MCI_CMD_READ;
   wire [24:0] tmr_count =
      (state_reg == mci_pkg::ST_ER_PULSE) ? 25'(ERASE_PULSE_CYC) :
      (state_reg == mci_pkg::ST_PG_PULSE) ? PGM_PULSE_CYC :
      SETTLE_CYC;
   wire ver_ok = (cyc_rdata == data_reg);
   wire erased = (cyc_rdata == `MCI_ERASED_BYTE);
   wire pgm_limit = (pcount_reg == `MCI_MAX_PGM_PULSES);
   wire er_limit = (ecount_reg == `MCI_MAX_ERASE_PULSES);
   wire need_vpp = (req_op != mci_pkg::MCI_OP_READ) && (req_op != mci_pkg::MCI_OP_IDENT);
   wire [16:0] req_addr_eff = (req_op == mci_pkg::MCI_OP_IDENT) ?
      {16'h0000, req_addr[0]} : req_addr;
   wire id_parity_bad = (op_reg == mci_pkg::MCI_OP_IDENT) && !(^cyc_rdata);

   always_comb begin
      state_next = state_reg;
      vaddr_next = vaddr_reg;
      pcount_next = pcount_reg;
      ecount_next = ecount_reg;
      fail_next = fail_reg;
      unique case (state_reg)
         mci_pkg::ST_IDLE: if (req_valid) begin
            state_next = mci_pkg::ST_SETTLE;
            vaddr_next = `MCI_ERASE_START;
            pcount_next = 5'h00;
            ecount_next = 5'h00;
            fail_next = 1'b0;
         end
         mci_pkg::ST_SETTLE: if (tmr_exp) begin
            unique case (op_reg)
               mci_pkg::MCI_OP_READ: state_next = mci_pkg::ST_RD;
               mci_pkg::MCI_OP_IDENT: state_next = mci_pkg::ST_RD;
               mci_pkg::MCI_OP_PROGRAM: state_next = mci_pkg::ST_PG_SETUP;
               mci_pkg::MCI_OP_ERASE: state_next = mci_pkg::ST_ER_SETUP;
               default: state_next = mci_pkg::ST_RST1;
            endcase
         end
         mci_pkg::ST_RD: if (cyc_done) state_next = mci_pkg::ST_DONE;
         mci_pkg::ST_PG_SETUP: if (cyc_done) state_next = mci_pkg::ST_PG_DATA;
         mci_pkg::ST_PG_DATA: if (cyc_done) begin
            state_next = mci_pkg::ST_PG_PULSE;
            pcount_next = pcount_reg + 5'h01;
         end
         mci_pkg::ST_PG_PULSE: if (tmr_exp) state_next = mci_pkg::ST_PG_VCMD;
         mci_pkg::ST_PG_VCMD: if (cyc_done) state_next = mci_pkg::ST_PG_VREAD;
         mci_pkg::ST_PG_VREAD: if (cyc_done) begin
            if (ver_ok) begin
               state_next = mci_pkg::ST_RST1;
            end else if (pgm_limit) begin
               state_next = mci_pkg::ST_RST1;
               fail_next = 1'b1;
            end else begin
               state_next = mci_pkg::ST_PG_SETUP;
            end
         end
         mci_pkg::ST_ER_SETUP: if (cyc_done) state_next = mci_pkg::ST_ER_GO;
         mci_pkg::ST_ER_GO: if (cyc_done) begin
            state_next = mci_pkg::ST_ER_PULSE;
            ecount_next = ecount_reg + 5'h01;
         end
         mci_pkg::ST_ER_PULSE: if (tmr_exp) state_next = mci_pkg::ST_ER_VCMD;
         mci_pkg::ST_ER_VCMD: if (cyc_done) state_next = mci_pkg::ST_ER_VREAD;
         mci_pkg::ST_ER_VREAD: if (cyc_done) begin
            if (erased && (vaddr_reg == `MCI_LAST_ADDR)) begin
               state_next = mci_pkg::ST_RST1;
            end else if (erased) begin
               state_next = mci_pkg::ST_ER_VCMD;
               vaddr_next = vaddr_reg + 17'h0_0001;
            end else if (er_limit) begin
               state_next = mci_pkg::ST_RST1;
               fail_next = 1'b1;
            end else begin
               state_next = mci_pkg::ST_ER_SETUP;
            end
         end
         mci_pkg::ST_RST1: if (cyc_done) state_next = mci_pkg::ST_RST2;
         mci_pkg::ST_RST2: if (cyc_done) state_next = mci_pkg::ST_RDCMD;
         mci_pkg::ST_RDCMD: if (cyc_done) state_next = mci_pkg::ST_DONE;
         mci_pkg::ST_DONE: state_next = mci_pkg::ST_IDLE;
         default: state_next = mci_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge mclk or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         state_reg <= mci_pkg::ST_IDLE;
         vaddr_reg <= `MCI_ERASE_START;
         pcount_reg <= 5'h00;
         ecount_reg <= 5'h00;
         fail_reg <= 1'b0;
         act_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         vaddr_reg <= vaddr_next;
         pcount_reg <= pcount_next;
         ecount_reg <= ecount_next;
         fail_reg <= fail_next;
         act_reg <= act_reg ? !(cyc_done || tmr_exp) : (cyc_start || tmr_load);
      end
   end

   always_ff @(posedge mclk or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         op_reg <= mci_pkg::MCI_OP_READ;
         addr_reg <= 17'h0_0000;
         data_reg <= 8'h00;
         program_supply_high <= 1'b0;
         identify_trigger_hv <= 1'b0;
      end else if (take_req) begin
         op_reg <= req_op;
         addr_reg <= req_addr_eff;
         data_reg <= req_data;
         program_supply_high <= need_vpp;
         identify_trigger_hv <= (req_op == mci_pkg::MCI_OP_IDENT);
      end else if (state_reg == mci_pkg::ST_DONE) begin
         program_supply_high <= 1'b0;
         identify_trigger_hv <= 1'b0;
      end
   end

   always_ff @(posedge mclk or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         req_ready <= 1'b0;
         rsp_valid <= 1'b0;
         rsp_data <= 8'h00;
         rsp_fail <= 1'b0;
      end else begin
         req_ready <= (state_next == mci_pkg::ST_IDLE);
         rsp_valid <= (state_reg == mci_pkg::ST_DONE);
         if (state_reg == mci_pkg::ST_DONE) begin
            rsp_data <= cyc_rdata;
            rsp_fail <= fail_reg || id_parity_bad;
         end
      end
   end

   mci_cyc u_cyc (
      .clk(mclk),
      .rst_n(rst_n_reg),
      .start(cyc_start),
      .wr(!is_read),
      .addr(cyc_addr),
      .wdata(cyc_wdata),
      .dq_i(mem_dq_i),
      .done(cyc_done),
      .rdata(cyc_rdata),
      .pin_addr(mem_addr),
      .pin_dq(mem_dq_o),
      .pin_dq_oe(mem_dq_oe),
      .pin_ce_n(mem_ce_n),
      .pin_oe_n(mem_oe_n),
      .pin_we_n(mem_we_n)
   );

   mci_tmr u_tmr (
      .clk(mclk),
      .rst_n(rst_n_reg),
      .load(tmr_load),
      .count(tmr_count),
      .expired(tmr_exp)
   );

   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n_reg);

   a_pgm_pulse_cap: assert property (pcount_reg <= `MCI_MAX_PGM_PULSES)
      else $error("program pulse count above limit");

   a_erase_pulse_cap: assert property (ecount_reg <= `MCI_MAX_ERASE_PULSES)
      else $error("erase pulse count above limit");

   a_verify_after_pulse: assert property (
      (state_reg == mci_pkg::ST_PG_PULSE && tmr_exp) |=> state_reg == mci_pkg::ST_PG_VCMD)
      else $error("program pulse not followed by verify");

   a_verify_from_zero: assert property (
      (state_reg == mci_pkg::ST_ER_GO && cyc_done && ecount_reg == 5'h00)
      |=> (vaddr_reg == `MCI_ERASE_START && ecount_reg == 5'h01))
      else $error("first erase verify not at address zero");

   a_setup_then_data: assert property (
      $rose(state_reg == mci_pkg::ST_PG_DATA) |-> $past(state_reg) == mci_pkg::ST_PG_SETUP)
      else $error("program data write without set-up");

   a_reset_pair: assert property (
      (state_reg == mci_pkg::ST_RST1 && cyc_done) |=> state_reg == mci_pkg::ST_RST2 ##6
      (!mem_we_n && mem_dq_o == `MCI_CMD_RESET))
      else $error("reset command not written twice");

   a_vpp_on_verify: assert property (
      (state_reg == mci_pkg::ST_PG_VREAD && !mem_oe_n) |-> (program_supply_high && !mem_ce_n
      && mem_we_n && !mem_dq_oe))
      else $error("program verify read without supply high");

   a_ident_lines_low: assert property (
      (identify_trigger_hv && cyc_start) |=> (mem_addr[16:1] == 16'h0000))
      else $error("identify read with upper address lines set");

   a_erase_resume: assert property (
      (state_reg == mci_pkg::ST_ER_VREAD && cyc_done && !erased && !er_limit)
      |=> (state_reg == mci_pkg::ST_ER_SETUP && $stable(vaddr_reg)))
      else $error("erase retry lost the failing address");

endmodule

// *** mci_dev_model.sv ***
`timescale 1ns/1ps

module mci_dev_model #(
   parameter logic [7:0] MFR_ID = 8'h8A, // arbitrary value, odd parity
   parameter logic [7:0] DEV_ID = 8'h15, // arbitrary value, odd parity
   parameter logic [7:0] PGM_VERIFY_CMD = 8'hC0
) (
   input wire logic [16:0] addr, // address pins
   input wire logic [7:0] dq, // data pins as resolved
   input wire logic ce_n, // chip select, active low
   input wire logic oe_n, // output gate, active low
   input wire logic we_n, // write strobe, active low
   input wire logic vpp_high, // program supply at high voltage
   input wire logic id_hv, // high voltage on identify trigger line
   output logic [7:0] dq_out, // read data
   output logic dq_en // device drives data pins
);
   logic [7:0] mem [0:131071];
   logic [2:0] mode;
   logic [16:0] lat_addr;
   logic [16:0] ver_addr;
   int pgm_cnt;
   int er_cnt;
   int ev_cnt;
   logic vcc_ok; // logic supply above four volts

   initial begin
      for (int i = 0; i < 131072; i++) begin
         mem[i] = 8'hFF;
      end
      mode = 3'h0;
      lat_addr = 17'h0_0000;
      ver_addr = 17'h0_0000;
      pgm_cnt = 0;
      er_cnt = 0;
      ev_cnt = 0;
      vcc_ok = 1'b1;
   end

   always @(negedge vpp_high) mode = 3'h0;

   always @(negedge we_n) begin
      if (!ce_n) lat_addr = addr;
   end

   // modes: 0 read, 1 set-up program, 2 set-up erase, 3 erase verify, 4 program verify
   always @(posedge we_n) begin
      if (!ce_n && vpp_high && vcc_ok) begin
         if (mode == 3'h1) begin
            mem[lat_addr] = mem[lat_addr] & dq;
            pgm_cnt++;
            mode = 3'h0;
         end else if (mode == 3'h2 && dq == 8'h20) begin
            for (int i = 0; i < 131072; i++) begin
               mem[i] = 8'hFF;
            end
            // one slow cell at address 1 stays unerased after the first pulse
            if (er_cnt == 0) mem[1] = 8'h7F;
            er_cnt++;
            mode = 3'h0;
         end else if (dq == 8'h20) begin
            mode = 3'h2;
         end else if (dq == 8'h40) begin
            mode = 3'h1;
         end else if (dq == 8'hA0) begin
            mode = 3'h3;
            ver_addr = lat_addr;
            ev_cnt++;
         end else if (dq == PGM_VERIFY_CMD) begin
            mode = 3'h4;
         end else begin
            mode = 3'h0;
         end
      end
   end

   assign dq_en = !ce_n && !oe_n && we_n;
   assign dq_out = (id_hv && addr[16:1] == 16'h0000) ? (addr[0] ? DEV_ID : MFR_ID) :
      (mode == 3'h3) ? mem[ver_addr] : mem[addr];
endmodule

// *** testbench.sv ***
`timescale 1ns/1ps

module testbench;
   localparam int OP_LIMIT = 80000;
   localparam int RUN_LIMIT = 90000;
   typedef struct {
      mci_pkg::mci_op_e op;
      logic [16:0] addr;
      logic [7:0] data;
      logic chk_data;
      logic [7:0] exp_data;
      logic exp_fail;
      int exp_pulses;
   } mci_row_s;

   logic mclk = 1'b0;
   logic rstn = 1'b1;
   logic req_valid = 1'b0;
   mci_pkg::mci_op_e req_op = mci_pkg::MCI_OP_READ;
   logic [16:0] req_addr = 17'h0_0000;
   logic [7:0] req_data = 8'h00;
   logic req_ready, rsp_valid, rsp_fail, mem_dq_oe, mem_ce_n, mem_oe_n, mem_we_n;
   logic program_supply_high, identify_trigger_hv, dev_en;
   logic [7:0] rsp_data, mem_dq_o, mem_dq_i, dev_dq;
   logic [16:0] mem_addr;
   int fails = 0;
   int check_count = 0;
   int cycles = 0;
   int n;
   mci_row_s r;
   // ordinary cases; the 0xF0 program cannot set cleared bits again, so it runs out of pulses
   mci_row_s rows [0:9] = '{
      '{mci_pkg::MCI_OP_READ, 17'h0_0010, 8'h00, 1'b1, 8'hFF, 1'b0, 0},
      '{mci_pkg::MCI_OP_IDENT, 17'h0_0000, 8'h00, 1'b1, 8'h8A, 1'b0, 0},
      '{mci_pkg::MCI_OP_IDENT, 17'h0_0001, 8'h00, 1'b1, 8'h15, 1'b0, 0},
      '{mci_pkg::MCI_OP_PROGRAM, 17'h0_0010, 8'h5A, 1'b1, 8'h5A, 1'b0, 1},
      '{mci_pkg::MCI_OP_READ, 17'h0_0010, 8'h00, 1'b1, 8'h5A, 1'b0, 0},
      '{mci_pkg::MCI_OP_READ, 17'h0_0011, 8'h00, 1'b1, 8'hFF, 1'b0, 0},
      '{mci_pkg::MCI_OP_PROGRAM, 17'h0_0010, 8'hF0, 1'b1, 8'h50, 1'b1, 25},
      '{mci_pkg::MCI_OP_RESET, 17'h0_0000, 8'h00, 1'b0, 8'h00, 1'b0, 0},
      '{mci_pkg::mci_op_e'(3'h5), 17'h0_0000, 8'h00, 1'b0, 8'h00, 1'b0, 0},
      '{mci_pkg::MCI_OP_READ, 17'h0_0010, 8'h00, 1'b1, 8'h50, 1'b0, 0}
   };

   always #2 mclk = ~mclk;

   // a released data bus shows a changing pattern, never the last value
   assign mem_dq_i = mem_dq_oe ? mem_dq_o : dev_en ? dev_dq : (cycles[7:0] ^ 8'h5A);

   mci_host #(.ERASE_PULSE_CYC(50)) i_dut (.mclk(mclk), .rstn(rstn), .req_valid(req_valid),
      .req_op(req_op), .req_addr(req_addr), .req_data(req_data), .req_ready(req_ready),
      .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_fail(rsp_fail), .mem_addr(mem_addr),
      .mem_dq_o(mem_dq_o), .mem_dq_oe(mem_dq_oe), .mem_dq_i(mem_dq_i), .mem_ce_n(mem_ce_n),
      .mem_oe_n(mem_oe_n), .mem_we_n(mem_we_n), .program_supply_high(program_supply_high),
      .identify_trigger_hv(identify_trigger_hv));

   mci_dev_model i_model (.addr(mem_addr), .dq(mem_dq_i), .ce_n(mem_ce_n), .oe_n(mem_oe_n),
      .we_n(mem_we_n), .vpp_high(program_supply_high), .id_hv(identify_trigger_hv),
      .dq_out(dev_dq), .dq_en(dev_en));

   task automatic complete_run();
      if (fails == 0 && check_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         fails++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic step();
      @(posedge mclk);
      #1;
   endtask

   task automatic issue(input mci_row_s q);
      n = 0;
      while (req_ready !== 1'b1 && n < OP_LIMIT) begin
         step();
         n++;
      end
      req_op = q.op;
      req_addr = q.addr;
      req_data = q.data;
      req_valid = 1'b1;
      step();
      req_valid = 1'b0;
   endtask

   task automatic run_op(input mci_row_s q);
      int p0;
      p0 = i_model.pgm_cnt;
      issue(q);
      n = 0;
      while (rsp_valid !== 1'b1 && n < OP_LIMIT) begin
         step();
         n++;
      end
      chk(rsp_valid, 1'b1);
      if (q.chk_data) chk(rsp_data, q.exp_data);
      chk(rsp_fail, q.exp_fail);
      chk(i_model.pgm_cnt - p0, q.exp_pulses);
      chk(i_model.mode, 3'h0);
   endtask

   always @(posedge mclk) begin
      cycles <= cycles + 1;
      if (cycles == RUN_LIMIT) begin
         fails++;
         complete_run();
      end
   end

   initial begin
      // dropped after time zero so the asynchronous reset sees an edge
      #1;
      rstn = 1'b0;
      repeat (5) @(posedge mclk);
      #1;
      chk({mem_ce_n, mem_oe_n, mem_we_n, mem_dq_oe, req_ready}, 5'b11100);
      rstn = 1'b1;
      step();
      step();
      chk(req_ready, 1'b0);
      step();
      chk(req_ready, 1'b1);
      for (int i = 0; i < 10; i++) begin
         run_op(rows[i]);
      end
      // erase: the slow cell at 1 forces a second pulse and a resume there, then reset mid-run
      r = '{mci_pkg::MCI_OP_ERASE, 17'h0_0000, 8'h00, 1'b0, 8'h00, 1'b0, 0};
      issue(r);
      n = 0;
      while (i_model.ev_cnt < 3 && n < OP_LIMIT) begin
         step();
         n++;
      end
      chk(i_model.er_cnt, 2);
      chk(i_model.ver_addr, 17'h0_0001);
      chk(i_model.mem[17'h0_0001], 8'hFF);
      chk(i_model.mem[17'h0_0010], 8'hFF);
      rstn = 1'b0;
      step();
      chk({mem_ce_n, mem_oe_n, mem_we_n, mem_dq_oe, program_supply_high}, 5'b11100);
      repeat (5) step();
      rstn = 1'b1;
      r = '{mci_pkg::MCI_OP_READ, 17'h0_0010, 8'h00, 1'b1, 8'hFF, 1'b0, 0};
      run_op(r);
      complete_run();
   end
endmodule
